// file: hw/chip_cfg_pkg.sv
// Contract
// - Muxed mode puts address and data on shared lines
// - 360-pin non-muxed: address on 32 PCI lines
// - 256-pin non-muxed: address on low 24 PCI lines
// - 256-pin bus field decode, 011/111 reserved
// - Serial boot may yield unlisted bus encodings
// - Bit 4 reports PLL or limp clocking
// - PCI enabled: bit 3 reports host or agent
// - PCI disabled: bit 3 reports oscillator bypass
// - PCI enabled: one bit reports 33/66 slew
// - PCI multiplier codes give 12,6,16,8 times reference
// - Bits 15 to 10 always read zero
// - Bits 9 and 8 always read one
// - Low byte holds chosen reset configuration, default otherwise
// - Register is read-only, writes change nothing
package chip_cfg_pkg;

    // Register map
    localparam logic [31:0] CHIP_CFG_ADDR    = 32'hFC0A0004;
    localparam logic [15:0] CHIP_CFG_HI_BITS = 16'h0300;
    localparam logic [7:0]  DEFAULT_CFG_BYTE = 8'h46;

    // Field positions inside the low byte
    localparam int BUS_SEL_MSB = 7;
    localparam int BUS_SEL_LSB = 5;
    localparam int CLK_SRC_BIT = 4;
    localparam int ROLE_OSC_BIT = 3;
    localparam int SLEW_BIT    = 2;

    // Bus select encodings with PCI on the larger package
    localparam logic [2:0] BUS_PCI_16 = 3'h3;
    localparam logic [2:0] BUS_PCI_8  = 3'h7;

    // Boot mode pin encodings
    localparam logic [1:0] BOOT_DEFAULT = 2'h0;
    localparam logic [1:0] BOOT_RSVD    = 2'h1;
    localparam logic [1:0] BOOT_PINS    = 2'h2;
    localparam logic [1:0] BOOT_SERIAL  = 2'h3;

    // Cycles the pin synchronisers need before a capture is trusted
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;

    // AHB transfer type codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    // Port size codes
    typedef enum logic [1:0] {
        PORT_32 = 2'h0,
        PORT_8  = 2'h1,
        PORT_16 = 2'h2,
        PORT_NA = 2'h3
    } port_size_t;

    // Decoded configuration as seen by the rest of the chip
    typedef struct packed {
        logic       valid;      // Capture finished
        logic       reserved;   // Bus select is not a listed encoding
        logic       muxed;      // Address and data share lines
        port_size_t port_size;
        logic       pci_enable;
        logic       pci_host;
        logic       osc_bypass;
        logic       limp;
        logic       slew_66;
        logic [4:0] vco_mult;   // VCO over reference clock
    } cfg_fields_t;

    // External bus request from the bus controller
    typedef struct packed {
        logic        addr_phase;
        logic        data_drive;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ext_bus_t;

    // Line drive toward the pads
    typedef struct packed {
        logic [31:0] shared_out;
        logic [31:0] shared_oe;
        logic [31:0] pci_out;
        logic [31:0] pci_oe;
    } line_drive_t;

endpackage

// file: hw/cfg_capture.sv
`timescale 1ns/1ps
// Samples boot pins through synchronisers and latches the config byte
module cfg_capture (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [1:0] boot_mode_pins,
    input  wire logic [7:0] shared_addr_data_lines_in,
    input  wire logic       package_256_strap,
    input  wire logic       serial_cfg_valid,
    input  wire logic [7:0] serial_cfg,
    output logic            cfg_done,
    output logic            is_256,
    output logic [7:0]      cfg_byte
);

    // One-hot capture sequence
    typedef enum logic [2:0] {
        ST_SETTLE = 3'h1,
        ST_SERIAL = 3'h2,
        ST_DONE   = 3'h4
    } cap_state_t;

    typedef struct packed {
        logic [10:0] sync1;     // First stage, read only by sync2
        logic [10:0] sync2;
        cap_state_t  state;
        logic [1:0]  settle;
        logic        is_256;
        logic [7:0]  cfg_byte;
    } cap_t;

    cap_t cap_reg;              // Registered state
    cap_t cap_next;             // Next state

    logic [10:0] pins_raw;      // All asynchronous straps in one vector
    logic [1:0]  mode_s;        // Synchronised boot mode
    logic [7:0]  lines_s;       // Synchronised override byte

    assign pins_raw = {package_256_strap, boot_mode_pins, shared_addr_data_lines_in};
    assign mode_s   = cap_reg.sync2[9:8];
    assign lines_s  = cap_reg.sync2[7:0];

    // Capture sequence; once done only the synchronisers change until the next reset
    always_comb begin
        cap_next       = cap_reg;
        cap_next.sync1 = pins_raw;
        cap_next.sync2 = cap_reg.sync1;
        case (cap_reg.state)
            ST_SETTLE: begin
                if (cap_reg.settle != chip_cfg_pkg::SETTLE_CYCLES) begin
                    cap_next.settle = cap_reg.settle + 2'h1;
                end else begin
                    cap_next.is_256 = cap_reg.sync2[10];
                    case (mode_s)
                        chip_cfg_pkg::BOOT_PINS: begin
                            cap_next.cfg_byte = lines_s;
                            cap_next.state    = ST_DONE;
                        end
                        chip_cfg_pkg::BOOT_SERIAL: begin
                            cap_next.state = ST_SERIAL;
                        end
                        // Defaults, and the reserved code, keep defaults
                        default: begin
                            cap_next.cfg_byte = chip_cfg_pkg::DEFAULT_CFG_BYTE;
                            cap_next.state    = ST_DONE;
                        end
                    endcase
                end
            end
            ST_SERIAL: begin
                // Serial data is taken as loaded, even if unlisted
                if (serial_cfg_valid) begin
                    cap_next.cfg_byte = serial_cfg;
                    cap_next.state    = ST_DONE;
                end
            end
            ST_DONE: begin
                cap_next.state = ST_DONE;
            end
            default: begin
                cap_next.state = ST_SETTLE;
            end
        endcase
    end

    // Reset loads constants only; pins are read after release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_reg <= '{sync1: 11'h000, sync2: 11'h000, state: ST_SETTLE,
                         settle: 2'h0, is_256: 1'b0,
                         cfg_byte: chip_cfg_pkg::DEFAULT_CFG_BYTE};
        end else begin
            cap_reg <= cap_next;
        end
    end

    assign cfg_done = (cap_reg.state == ST_DONE);
    assign is_256   = cap_reg.is_256;
    assign cfg_byte = cap_reg.cfg_byte;

endmodule

// file: hw/bus_line_router.sv
`timescale 1ns/1ps
// Steers external bus address and data onto the pad lines
module bus_line_router (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      cfg_done,
    input  wire logic                      is_256,
    input  wire logic                      muxed,
    input  wire chip_cfg_pkg::ext_bus_t    ext_bus,
    output chip_cfg_pkg::line_drive_t      lines
);

    typedef struct packed {
        chip_cfg_pkg::line_drive_t drive;
    } rt_t;

    rt_t rt_reg;                // Registered pad drive
    rt_t rt_next;               // Next pad drive

    logic [31:0] pci_mask;      // Smaller package has 24 address lines

    assign pci_mask = is_256 ? 32'h00FFFFFF : 32'hFFFFFFFF;

    // Nothing is driven until the configuration is known
    always_comb begin
        rt_next = '0;
        if (cfg_done) begin
            if (muxed) begin
                // Address phase then data phase on one set of lines
                if (ext_bus.addr_phase) begin
                    rt_next.drive.shared_out = ext_bus.addr;
                    rt_next.drive.shared_oe  = 32'hFFFFFFFF;
                end else if (ext_bus.data_drive) begin
                    rt_next.drive.shared_out = ext_bus.wdata;
                    rt_next.drive.shared_oe  = 32'hFFFFFFFF;
                end
            end else begin
                // Data alone on shared lines, address on PCI lines
                if (ext_bus.data_drive) begin
                    rt_next.drive.shared_out = ext_bus.wdata;
                    rt_next.drive.shared_oe  = 32'hFFFFFFFF;
                end
                if (ext_bus.addr_phase) begin
                    rt_next.drive.pci_out = ext_bus.addr & pci_mask;
                    rt_next.drive.pci_oe  = pci_mask;
                end
            end
        end
    end

    // Pads are driven from flops so they stay glitch free
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rt_reg <= '0;
        end else begin
            rt_reg <= rt_next;
        end
    end

    assign lines = rt_reg.drive;

endmodule

// file: hw/reset_config_status_reg.sv
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Reset-time chip configuration status, read over AHB-Lite
module reset_config_status_reg (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic                      hready,
    input  wire logic [31:0]               hwdata,
    output logic [31:0]                    hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // Boot straps, outside this clock
    input  wire logic [1:0]                boot_mode_pins,
    input  wire logic [7:0]                shared_addr_data_lines_in,
    input  wire logic                      package_256_strap,
    // Serial boot loader, same clock
    input  wire logic                      serial_cfg_valid,
    input  wire logic [7:0]                serial_cfg,
    // External bus controller and pads
    input  wire chip_cfg_pkg::ext_bus_t    ext_bus,
    output chip_cfg_pkg::line_drive_t      lines,
    // Decoded configuration
    output chip_cfg_pkg::cfg_fields_t      cfg
);

    // All registered state of this level
    typedef struct packed {
        logic [31:0]               rdata;
        chip_cfg_pkg::cfg_fields_t fields;
    } top_t;

    top_t top_reg;              // Registered state
    top_t top_next;             // Next state

    logic        cfg_done;      // Capture has finished
    logic        is_256;        // Smaller package variant
    logic [7:0]  cfg_byte;      // Captured low byte
    logic [2:0]  bus_sel;       // Bus mux and port size select
    logic [15:0] status_word;   // Full register image
    logic        addr_valid;    // Address phase taken this cycle
    logic        hit;           // Address matches the register

    // Straps are captured in their own block
    cfg_capture u_capture (
        .hclk                      (hclk),
        .hresetn                   (hresetn),
        .boot_mode_pins            (boot_mode_pins),
        .shared_addr_data_lines_in (shared_addr_data_lines_in),
        .package_256_strap         (package_256_strap),
        .serial_cfg_valid          (serial_cfg_valid),
        .serial_cfg                (serial_cfg),
        .cfg_done                  (cfg_done),
        .is_256                    (is_256),
        .cfg_byte                  (cfg_byte)
    );

    // Pad steering follows the registered mux decision
    bus_line_router u_router (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .cfg_done (top_reg.fields.valid),
        .is_256   (is_256),
        .muxed    (top_reg.fields.muxed),
        .ext_bus  (ext_bus),
        .lines    (lines)
    );

    assign bus_sel = cfg_byte[chip_cfg_pkg::BUS_SEL_MSB:chip_cfg_pkg::BUS_SEL_LSB];

    // Fixed upper byte around the captured low byte
    assign status_word = chip_cfg_pkg::CHIP_CFG_HI_BITS | {8'h00, cfg_byte};

    // A transfer is taken when selected, active and the bus is ready
    assign addr_valid = hsel && hready && (htrans == chip_cfg_pkg::HTRANS_NONSEQ ||
                                           htrans == chip_cfg_pkg::HTRANS_SEQ);
    assign hit = (haddr == chip_cfg_pkg::CHIP_CFG_ADDR);

    // Decode of the captured byte and the bus read path
    always_comb begin
        top_next = top_reg;
        top_next.fields.valid = cfg_done;
        top_next.fields.limp  = cfg_byte[chip_cfg_pkg::CLK_SRC_BIT];

        // PCI exists only on the larger package with the two PCI codes
        top_next.fields.pci_enable = !is_256 &&
            (bus_sel == chip_cfg_pkg::BUS_PCI_16 || bus_sel == chip_cfg_pkg::BUS_PCI_8);
        top_next.fields.reserved = is_256 &&
            (bus_sel == chip_cfg_pkg::BUS_PCI_16 || bus_sel == chip_cfg_pkg::BUS_PCI_8);

        // Upper select bit chooses muxed operation; both PCI codes are muxed too,
        // since the PCI pins then carry no external bus address
        top_next.fields.muxed = bus_sel[2] || top_next.fields.pci_enable;
        case (bus_sel[1:0])
            2'h0: top_next.fields.port_size = chip_cfg_pkg::PORT_32;
            2'h1: top_next.fields.port_size = chip_cfg_pkg::PORT_8;
            2'h2: top_next.fields.port_size = chip_cfg_pkg::PORT_16;
            // Code 3: PCI sizes on the larger package, reserved otherwise
            default: begin
                if (is_256) begin
                    top_next.fields.port_size = chip_cfg_pkg::PORT_NA;
                end else if (bus_sel[2]) begin
                    top_next.fields.port_size = chip_cfg_pkg::PORT_8;
                end else begin
                    top_next.fields.port_size = chip_cfg_pkg::PORT_16;
                end
            end
        endcase

        // Bit 3 and the multiplier change meaning with PCI
        if (top_next.fields.pci_enable) begin
            top_next.fields.pci_host   = cfg_byte[chip_cfg_pkg::ROLE_OSC_BIT];
            top_next.fields.osc_bypass = 1'b0;
            top_next.fields.slew_66    = cfg_byte[chip_cfg_pkg::SLEW_BIT];
            case (cfg_byte[1:0])
                2'h0: top_next.fields.vco_mult = 5'h0C;
                2'h1: top_next.fields.vco_mult = 5'h06;
                2'h2: top_next.fields.vco_mult = 5'h10;
                default: top_next.fields.vco_mult = 5'h08;
            endcase
        end else begin
            top_next.fields.pci_host   = 1'b0;
            top_next.fields.osc_bypass = cfg_byte[chip_cfg_pkg::ROLE_OSC_BIT];
            top_next.fields.slew_66    = 1'b0;
            // Three-bit multiplier for PCI-less configurations
            case (cfg_byte[2:0])
                3'h0: top_next.fields.vco_mult = 5'h14;
                3'h1: top_next.fields.vco_mult = 5'h0A;
                3'h2: top_next.fields.vco_mult = 5'h18;
                3'h3: top_next.fields.vco_mult = 5'h12;
                3'h4: top_next.fields.vco_mult = 5'h0C;
                3'h5: top_next.fields.vco_mult = 5'h06;
                3'h6: top_next.fields.vco_mult = 5'h10;
                default: top_next.fields.vco_mult = 5'h08;
            endcase
        end

        // Read data is loaded at the address phase and stands in the data phase;
        // writes are accepted with OKAY and discarded, so hwdata is never used
        if (addr_valid) begin
            if (hit && !hwrite) begin
                top_next.rdata = {16'h0000, status_word};
            end else begin
                top_next.rdata = 32'h00000000;
            end
        end
    end

    // Single register stage for all state at this level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            top_reg <= '0;
        end else begin
            top_reg <= top_next;
        end
    end

    // Zero wait states; the only answer is OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = top_reg.rdata;
    assign cfg       = top_reg.fields;

endmodule

// file: verification/reset_config_status_reg_checker.sv
`timescale 1ns/1ps
// Watches the status word and the line steering from the top ports
module reset_config_status_reg_checker (
    input wire logic                        hclk,
    input wire logic                        hresetn,
    input wire logic                        hsel,
    input wire logic [31:0]                 haddr,
    input wire logic [1:0]                  htrans,
    input wire logic                        hwrite,
    input wire logic                        hready,
    input wire logic [31:0]                 hrdata,
    input wire logic                        hreadyout,
    input wire logic                        hresp,
    input wire logic                        package_256_strap,
    input wire chip_cfg_pkg::ext_bus_t      ext_bus,
    input wire chip_cfg_pkg::line_drive_t   lines,
    input wire chip_cfg_pkg::cfg_fields_t   cfg
);
    logic rd_take;   // Status word read taken this edge
    logic rd_valid;  // Same, after capture finished

    // Decode of a status read; the data phase follows one edge later
    assign rd_take  = hsel && hready && htrans[1] && !hwrite
                      && haddr == chip_cfg_pkg::CHIP_CFG_ADDR;
    assign rd_valid = rd_take && cfg.valid;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    hi_bits_a: assert property (rd_take |=> hrdata[31:8] == 24'h000003)
        else $error("upper status bits wrong");
    clk_mode_a: assert property (rd_valid |=> hrdata[4] == cfg.limp)
        else $error("clock mode bit disagrees");
    role_osc_a: assert property (rd_valid |=>
        hrdata[3] == (cfg.pci_enable ? cfg.pci_host : cfg.osc_bypass))
        else $error("bit 3 meaning wrong");
    slew_bit_a: assert property (rd_valid && cfg.pci_enable |=> hrdata[2] == cfg.slew_66)
        else $error("slew bit disagrees");
    pci_mult_a: assert property (rd_valid && cfg.pci_enable |=> cfg.vco_mult ==
        (hrdata[1] ? (hrdata[0] ? 5'h08 : 5'h10) : (hrdata[0] ? 5'h06 : 5'h0C)))
        else $error("multiplier decode wrong");
    bus_decode_a: assert property (rd_valid && package_256_strap |=>
        cfg.reserved == (hrdata[6:5] == 2'h3) && (cfg.reserved || cfg.muxed == hrdata[7]))
        else $error("narrow package bus decode wrong");
    cfg_held_a: assert property (cfg.valid |=> $stable(cfg))
        else $error("captured configuration moved");
    write_okay_a: assert property (cfg.valid && hsel && htrans[1] && hwrite |=>
        !hresp && hreadyout && $stable(cfg))
        else $error("write not ignored");
    mux_lines_a: assert property (cfg.valid && cfg.muxed && ext_bus.addr_phase |=>
        lines.shared_out == $past(ext_bus.addr) && lines.shared_oe == 32'hFFFFFFFF)
        else $error("muxed address not on shared lines");
    pci_lines_a: assert property (cfg.valid && !cfg.muxed && ext_bus.addr_phase |=>
        lines.pci_out[23:0] == $past(ext_bus.addr[23:0])
        && lines.pci_oe == (package_256_strap ? 32'h00FFFFFF : 32'hFFFFFFFF))
        else $error("address not on pci lines");

    // Main scenarios reached
    cover property (rd_valid && cfg.pci_enable);
    cover property (hsel && htrans[1] && hwrite);
    cover property (cfg.valid && cfg.muxed && ext_bus.addr_phase);
endmodule

// file: verification/tb_reset_config_status_reg.sv
`timescale 1ns/1ps
// Self-checking bench: boots each strap mode, reads the word, steers lines
module tb_reset_config_status_reg;
    logic                       hclk;
    logic                       hresetn;
    logic                       hsel;
    logic [31:0]                haddr;
    logic [1:0]                 htrans;
    logic                       hwrite;
    logic [2:0]                 hsize;
    logic                       hready;
    logic [31:0]                hwdata;
    logic [31:0]                hrdata;
    logic                       hreadyout;
    logic                       hresp;
    logic [1:0]                 boot_mode_pins;
    logic [7:0]                 pin_byte;
    logic                       package_256_strap;
    logic                       serial_cfg_valid;
    logic [7:0]                 serial_cfg;
    chip_cfg_pkg::ext_bus_t     ext_bus;
    chip_cfg_pkg::line_drive_t  lines;
    chip_cfg_pkg::cfg_fields_t  cfg;
    int                         err_count;
    int                         checks_done;
    logic [4:0]                 pci_mult [4] = '{5'h0C, 5'h06, 5'h10, 5'h08};

    // One slave, so its ready is the bus ready
    assign hready = hreadyout;

    reset_config_status_reg reset_config_status_reg_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
        .hrdata, .hreadyout, .hresp, .boot_mode_pins, .shared_addr_data_lines_in(pin_byte),
        .package_256_strap, .serial_cfg_valid, .serial_cfg, .ext_bus, .lines, .cfg
    );

    // Clock at 40 MHz
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cfg(input chip_cfg_pkg::cfg_fields_t exp);
        checks_done++;
        if (cfg !== exp) begin
            err_count++;
            $display("Error at %0t: cfg %h expected %h", $time, cfg, exp);
        end
    endtask

    // Single AHB transfer; waits for ready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= chip_cfg_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // Full chip reset with the given straps, then wait for capture
    task automatic boot(input logic [1:0] mode, input logic [7:0] pb, input logic p256,
                        input logic [7:0] ser);
        int i;
        hresetn           <= 1'b0;
        boot_mode_pins    <= mode;
        pin_byte          <= pb;
        package_256_strap <= p256;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        if (mode == chip_cfg_pkg::BOOT_SERIAL) begin
            repeat (10) @(posedge hclk);
            chk_word({31'h0, cfg.valid}, 32'h0);
            serial_cfg       <= ser;
            serial_cfg_valid <= 1'b1;
            @(posedge hclk);
            serial_cfg_valid <= 1'b0;
        end
        for (i = 0; i < 40 && cfg.valid !== 1'b1; i++) @(posedge hclk);
        repeat (2) @(posedge hclk);
        chk_word({31'h0, cfg.valid}, 32'h1);
    endtask

    // One cycle of bus request; lines are settled one edge later
    task automatic drive_bus(input logic ap, input logic dd, input logic [31:0] a,
                             input logic [31:0] d);
        ext_bus <= {ap, dd, a, d};
        @(posedge hclk);
        ext_bus <= '0;
        #1;
    endtask

    task automatic t_default;
        logic [31:0] rd;
        boot(chip_cfg_pkg::BOOT_DEFAULT, 8'hFF, 1'b0, 8'h00);
        chk_cfg({3'h4, chip_cfg_pkg::PORT_16, 5'h00, 5'h10});
        ahb(1'b0, chip_cfg_pkg::CHIP_CFG_ADDR, 32'h0, rd);
        chk_word(rd, 32'h00000346);
        ahb(1'b1, chip_cfg_pkg::CHIP_CFG_ADDR, 32'hFFFFFFFF, rd);
        ahb(1'b0, chip_cfg_pkg::CHIP_CFG_ADDR, 32'h0, rd);
        chk_word(rd, 32'h00000346);
        ahb(1'b0, chip_cfg_pkg::CHIP_CFG_ADDR + 32'h00000100, 32'h0, rd);
        chk_word(rd, 32'h0);
        drive_bus(1'b1, 1'b0, 32'h12345678, 32'h0);
        chk_word(lines.pci_out, 32'h12345678);
        chk_word(lines.pci_oe, 32'hFFFFFFFF);
        @(posedge hclk);
        drive_bus(1'b0, 1'b1, 32'h0, 32'hCAFE0001);
        chk_word(lines.shared_out, 32'hCAFE0001);
        @(posedge hclk);
        // Reserved boot code falls back to the defaults
        boot(chip_cfg_pkg::BOOT_RSVD, 8'h00, 1'b0, 8'h00);
        chk_cfg({3'h4, chip_cfg_pkg::PORT_16, 5'h00, 5'h10});
    endtask

    // Pin override: PCI on, every multiplier code, both roles and slews
    task automatic t_pins;
        logic [31:0] rd;
        logic [7:0]  pb;
        logic [1:0]  k;
        // PCI with a 16-bit port still shares address and data lines
        boot(chip_cfg_pkg::BOOT_PINS, 8'h60, 1'b0, 8'h00);
        chk_cfg({3'h5, chip_cfg_pkg::PORT_16, 5'h10, 5'h0C});
        for (int n = 0; n < 4; n++) begin
            k  = n[1:0];
            pb = {3'h7, k[0], k[0], k[1], k};
            boot(chip_cfg_pkg::BOOT_PINS, pb, 1'b0, 8'h00);
            chk_cfg({3'h5, chip_cfg_pkg::PORT_8, 1'b1, k[0], 1'b0,
                     k[0], k[1], pci_mult[n]});
            ahb(1'b0, chip_cfg_pkg::CHIP_CFG_ADDR, 32'h0, rd);
            chk_word(rd, {24'h000003, pb});
        end
        boot_mode_pins <= chip_cfg_pkg::BOOT_DEFAULT;
        pin_byte       <= 8'h00;
        repeat (10) @(posedge hclk);
        ahb(1'b0, chip_cfg_pkg::CHIP_CFG_ADDR, 32'h0, rd);
        chk_word(rd, {24'h000003, pb});
        drive_bus(1'b1, 1'b1, 32'hA5A50F0F, 32'h5A5A0000);
        chk_word(lines.shared_out, 32'hA5A50F0F);
        @(posedge hclk);
        drive_bus(1'b0, 1'b1, 32'h0, 32'h5A5A0000);
        chk_word(lines.shared_out, 32'h5A5A0000);
        @(posedge hclk);
    endtask

    // Serial loads on the narrow package, one of them a reserved code
    task automatic t_serial;
        logic [31:0] rd;
        boot(chip_cfg_pkg::BOOT_SERIAL, 8'h00, 1'b1, 8'h9F);
        chk_cfg({3'h5, chip_cfg_pkg::PORT_32, 5'h06, 5'h08});
        boot(chip_cfg_pkg::BOOT_SERIAL, 8'h00, 1'b1, 8'hE0);
        chk_word({30'h0, cfg.reserved, cfg.pci_enable}, 32'h2);
        ahb(1'b0, chip_cfg_pkg::CHIP_CFG_ADDR, 32'h0, rd);
        chk_word(rd, 32'h000003E0);
        boot(chip_cfg_pkg::BOOT_PINS, 8'h00, 1'b1, 8'h00);
        chk_cfg({3'h4, chip_cfg_pkg::PORT_32, 5'h00, 5'h14});
        drive_bus(1'b1, 1'b0, 32'h89ABCDEF, 32'h0);
        chk_word({8'h00, lines.pci_out[23:0]}, 32'h00ABCDEF);
        chk_word(lines.pci_oe, 32'h00FFFFFF);
        @(posedge hclk);
    endtask

    task automatic give_verdict;
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        err_count = 0;
        checks_done = 0;
        hresetn = 1'b0;
        {hsel, haddr, htrans, hwrite, hwdata, serial_cfg_valid, serial_cfg} = '0;
        hsize = 3'h2;
        {boot_mode_pins, pin_byte, package_256_strap} = '0;
        ext_bus = '0;
        @(posedge hclk);
        t_default();
        t_pins();
        t_serial();
        give_verdict();
    end

    // Hang guard, far beyond the expected run length
    initial begin
        repeat (5000) @(posedge hclk);
        err_count++;
        $display("Error at %0t: timeout", $time);
        give_verdict();
    end
endmodule

bind reset_config_status_reg reset_config_status_reg_checker chk_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
    .hresp, .package_256_strap, .ext_bus, .lines, .cfg
);
